//--- rtl/scrs_device.sv
// Device end: SMBus slave holding the configuration bytes
// Summary of operation
// - Two-wire slave port reads and writes bytes
// - Six transfer types: byte, word, block
// - Block transfers walk bytes upward from zero
// - Early block stop keeps completed bytes
// - Indexed transfers use offset from command
// - Command bit 7 selects block or indexed
// - Host puts offset in bits 6:0
// - Start, address, write bit, device acknowledges
// - Command byte follows, device acknowledges it
// - Block write count byte precedes data
// - Each written data byte is acknowledged
// - Block read: device sends byte count first
// - Data bytes follow; host ends with NACK
// - Word write sends low then high byte
module scrs_device
   import scrs_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = SCRS_DEV_ADDR, // Own slave address
   parameter int NUM_CFG = SCRS_NUM_CFG // Configuration bytes
)
(
   input wire logic clk_sys, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic clk_link, // Link-side oversampling clock
   scrs_if.device bus, // Two-wire link
   output logic cfg_wr_stb, // One-cycle pulse per stored byte
   output logic [$clog2(NUM_CFG)-1:0] cfg_wr_idx, // Index of stored byte
   output logic [7:0] cfg_wr_data // Value of stored byte
);
   localparam int AW = $clog2(NUM_CFG);
   localparam logic [7:0] BLK_CNT = 8'(NUM_CFG);

   // Link-domain state, including the byte array
   typedef struct packed {
      scrs_dstate_type st;
      logic scl_p;
      logic sda_p;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic oe;
      logic tx;
      logic ack_ok;
      logic blk;
      logic cnt_pend;
      logic wr_pend;
      logic [AW-1:0] ptr;
      logic [AW-1:0] wr_idx;
      logic [7:0] wr_dat;
      logic tgl;
      logic [NUM_CFG-1:0][7:0] mem;
   } scrs_link_type;

   // System-domain state
   typedef struct packed {
      logic tgl_p;
      logic stb;
      logic [AW-1:0] idx;
      logic [7:0] dat;
   } scrs_usr_type;

   scrs_link_type l_q;
   scrs_link_type l_d;
   scrs_usr_type u_q;
   scrs_usr_type u_d;
   logic rst_l;
   logic scl_s;
   logic sda_s;
   logic tgl_s;
   logic [7:0] byte_in;
   logic [7:0] tx_byte;

   // Reset and pins enter the link domain through two flops
   scrs_sync #(.W(1)) u_rst_sync
   (
      .clk(clk_link),
      .d(sys_rst),
      .q(rst_l)
   );

   scrs_sync #(.W(2)) u_pin_sync
   (
      .clk(clk_link),
      .d({bus.serial_clock_line, bus.serial_data_line}),
      .q({scl_s, sda_s})
   );

   // Write event toggle enters the system domain
   scrs_sync #(.W(1)) u_tgl_sync
   (
      .clk(clk_sys),
      .d(l_q.tgl),
      .q(tgl_s)
   );

   // Link engine: start/stop detection, bit shifting, acknowledge
   always_comb
   begin
      l_d = l_q;
      byte_in = {l_q.sh[6:0], sda_s};
      tx_byte = l_q.cnt_pend ? BLK_CNT : l_q.mem[l_q.ptr];
      l_d.scl_p = scl_s;
      l_d.sda_p = sda_s;
      if (scl_s && l_q.scl_p && l_q.sda_p && !sda_s)
      begin
         // Start or repeated start restarts the address phase
         l_d.st = DS_ADDR;
         l_d.bitn = '0;
         l_d.oe = 1'b0;
         l_d.tx = 1'b0;
         l_d.wr_pend = 1'b0;
      end
      else if (scl_s && l_q.scl_p && !l_q.sda_p && sda_s)
      begin
         // Stop: a byte not yet acknowledged is dropped
         l_d.st = DS_IDLE;
         l_d.oe = 1'b0;
         l_d.tx = 1'b0;
         l_d.wr_pend = 1'b0;
      end
      else if (l_q.st != DS_IDLE && scl_s && !l_q.scl_p)
      begin
         // Rising clock: sample a bit
         if (l_q.bitn == SCRS_BIT_ACK)
         begin
            // Host NACK ends the read; wait for stop
            if (l_q.tx && sda_s)
            begin
               l_d.st = DS_IDLE;
               l_d.tx = 1'b0;
            end
         end
         else if (l_q.bitn < SCRS_BIT_DONE)
         begin
            l_d.bitn = l_q.bitn + 4'h1;
            if (!l_q.tx)
            begin
               l_d.sh = byte_in;
            end
            if (!l_q.tx && l_q.bitn == SCRS_BIT_DONE - 4'h1)
            begin
               l_d.ack_ok = 1'b1;
               case (l_q.st)
                  DS_ADDR:
                  begin
                     if (byte_in[7:1] == DEV_ADDR)
                     begin
                        // Read bit turns the device into sender
                        l_d.st = byte_in[0] ? DS_RDATA : DS_CMD;
                     end
                     else
                     begin
                        l_d.ack_ok = 1'b0;
                        l_d.st = DS_IDLE;
                     end
                  end
                  DS_CMD:
                  begin
                     // Type bit picks block or indexed access
                     l_d.blk = !byte_in[SCRS_TYPE_BIT];
                     l_d.cnt_pend = !byte_in[SCRS_TYPE_BIT];
                     // Block always begins at byte zero
                     l_d.ptr = byte_in[SCRS_TYPE_BIT] ?
                        AW'(byte_in[SCRS_OFS_MSB:0]) : '0;
                     l_d.st = DS_WDATA;
                  end
                  DS_WDATA:
                  begin
                     if (l_q.cnt_pend)
                     begin
                        // Block count byte is acknowledged, not stored
                        l_d.cnt_pend = 1'b0;
                     end
                     else
                     begin
                        // Held until the acknowledge slot closes
                        l_d.wr_pend = 1'b1;
                        l_d.wr_dat = byte_in;
                        l_d.wr_idx = l_q.ptr;
                        l_d.ptr = l_q.ptr + 1'b1;
                     end
                  end
                  default:
                  begin
                     l_d.ack_ok = 1'b0;
                  end
               endcase
            end
         end
      end
      else if (l_q.st != DS_IDLE && !scl_s && l_q.scl_p)
      begin
         // Falling clock: change the line while the clock is low
         if (l_q.bitn == SCRS_BIT_DONE)
         begin
            l_d.bitn = SCRS_BIT_ACK;
            l_d.oe = !l_q.tx && l_q.ack_ok;
         end
         else if (l_q.bitn == SCRS_BIT_ACK)
         begin
            l_d.bitn = '0;
            l_d.oe = 1'b0;
            if (l_q.wr_pend)
            begin
               // Whole, acknowledged byte becomes visible
               l_d.mem[l_q.wr_idx] = l_q.wr_dat;
               l_d.wr_pend = 1'b0;
               l_d.tgl = !l_q.tgl;
            end
            l_d.tx = l_q.st == DS_RDATA;
            if (l_q.st == DS_RDATA)
            begin
               // Count byte first in block reads, then ascending data
               l_d.sh = tx_byte;
               l_d.oe = !tx_byte[7];
               l_d.cnt_pend = 1'b0;
               if (!l_q.cnt_pend)
               begin
                  l_d.ptr = l_q.ptr + 1'b1;
               end
            end
         end
         else if (l_q.tx)
         begin
            // Next bit of the byte being sent, MSB first
            l_d.sh = {l_q.sh[6:0], 1'b0};
            l_d.oe = !l_q.sh[6];
         end
      end
   end

   // Link-domain register, reset by the synchronised system reset
   always_ff @(posedge clk_link)
   begin
      if (rst_l)
      begin
         l_q <= '0;
         l_q.mem <= {NUM_CFG{SCRS_CFG_RESET}};
      end
      else
      begin
         l_q <= l_d;
      end
   end

   // Toggle edge announces a stored byte; its data is long stable
   always_comb
   begin
      u_d = u_q;
      u_d.stb = 1'b0;
      u_d.tgl_p = tgl_s;
      if (tgl_s != u_q.tgl_p)
      begin
         u_d.stb = 1'b1;
         u_d.idx = l_q.wr_idx;
         u_d.dat = l_q.wr_dat;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         u_q <= '0;
      end
      else
      begin
         u_q <= u_d;
      end
   end

   // Open-drain: only the enable ever changes
   assign bus.sda_dev_o = 1'b0;
   assign bus.sda_dev_oe = l_q.oe;
   assign cfg_wr_stb = u_q.stb;
   assign cfg_wr_idx = u_q.idx;
   assign cfg_wr_data = u_q.dat;
endmodule // scrs_device

//--- rtl/scrs_pkg.sv
// Shared constants, types and helpers of the SMBus configuration link
package scrs_pkg;
   // Arbitrary slave address value, not tied to any real part
   localparam logic [6:0] SCRS_DEV_ADDR = 7'h69;
   localparam int SCRS_NUM_CFG = 128; // Configuration bytes
   localparam logic [7:0] SCRS_CFG_RESET = 8'h00; // Byte value after reset
   localparam int SCRS_TYPE_BIT = 7; // Command bit: 1 indexed, 0 block
   localparam int SCRS_OFS_MSB = 6; // Offset field is bits 6:0
   localparam logic [7:0] SCRS_BLOCK_CMD = 8'h00; // Block command code
   localparam logic [3:0] SCRS_BIT_DONE = 4'h8; // Eight data bits seen
   localparam logic [3:0] SCRS_BIT_ACK = 4'h9; // Inside acknowledge slot
   // Host line timing: quarter of a 100 kHz bit, at least this long
   localparam int SCRS_QTR_NS = 2500;
   localparam int SCRS_SYS_NS = 20;
   localparam int SCRS_QTR_CYC = (SCRS_QTR_NS + SCRS_SYS_NS - 1) / SCRS_SYS_NS;

   typedef enum logic [2:0] {
      OP_BYTE_WR, OP_WORD_WR, OP_BYTE_RD, OP_WORD_RD, OP_BLK_WR, OP_BLK_RD
   } scrs_op_type;

   typedef enum logic [2:0] {
      DS_IDLE, DS_ADDR, DS_CMD, DS_WDATA, DS_RDATA
   } scrs_dstate_type;

   typedef enum logic [3:0] {
      HS_IDLE, HS_START, HS_ADDR, HS_CMD, HS_CNT, HS_WDATA,
      HS_RSTART, HS_RADDR, HS_RDATA, HS_STOP
   } scrs_hstate_type;

   // Operation decoding
   function automatic logic op_is_read(input scrs_op_type op);
      return op == OP_BYTE_RD || op == OP_WORD_RD || op == OP_BLK_RD;
   endfunction

   function automatic logic op_is_block(input scrs_op_type op);
      return op == OP_BLK_WR || op == OP_BLK_RD;
   endfunction

   // Data bytes of a transfer, not counting the block count byte
   function automatic logic [7:0] op_count(input scrs_op_type op,
                                           input logic [7:0] len);
      if (op_is_block(op))
         return len;
      return (op == OP_WORD_WR || op == OP_WORD_RD) ? 8'h02 : 8'h01;
   endfunction

   // Command code: type bit plus offset, all zero for block transfers
   function automatic logic [7:0] cmd_code(input scrs_op_type op,
                                           input logic [6:0] ofs);
      if (op_is_block(op))
         return SCRS_BLOCK_CMD;
      return {1'b1, ofs};
   endfunction
endpackage

//--- rtl/scrs_if.sv
// Two-wire link between host and configuration slave
interface scrs_if;
   logic serial_clock_line; // Clock, driven by host only
   logic sda_host_o; // Host data out, always low
   logic sda_host_oe; // Host pulls data low
   logic sda_dev_o; // Device data out, always low
   logic sda_dev_oe; // Device pulls data low
   logic serial_data_line; // Resolved data line

   // Open-drain wire with pull-up: any enabled low driver wins
   assign serial_data_line = !((sda_host_oe && !sda_host_o) ||
                               (sda_dev_oe && !sda_dev_o));

   modport host (output serial_clock_line, output sda_host_o,
                 output sda_host_oe, input serial_data_line);
   modport device (input serial_clock_line, input serial_data_line,
                   output sda_dev_o, output sda_dev_oe);
endinterface

//--- rtl/scrs_sync.sv
// Two-stage synchroniser for levels entering a clock domain
module scrs_sync
#(
   parameter int W = 1 // Bits synchronised
)
(
   input wire logic clk, // Destination clock
   input wire logic [W-1:0] d, // Asynchronous levels
   output logic [W-1:0] q // Synchronised levels
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } scrs_sync_type;

   scrs_sync_type s_q;
   scrs_sync_type s_d;

   // First stage feeds only the second stage
   always_comb
   begin
      s_d.s1 = d;
      s_d.s2 = s_q.s1;
   end

   // No reset: a synchroniser settles on its own within two edges
   always_ff @(posedge clk)
   begin
      s_q <= s_d;
   end

   assign q = s_q.s2;
endmodule // scrs_sync

//--- rtl/scrs_host.sv
// Host end: SMBus master issuing configuration transfers
module scrs_host
   import scrs_pkg::*;
#(
   parameter int QTR_CYC = SCRS_QTR_CYC // Cycles per quarter bit
)
(
   input wire logic clk_sys, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   scrs_if.host bus, // Two-wire link
   input wire logic go, // Start a transfer, pulse while idle
   input wire scrs_op_type op, // Transfer type
   input wire logic [6:0] addr, // Slave address
   input wire logic [6:0] offset, // Byte offset, indexed transfers
   input wire logic [7:0] len, // Block byte count
   input wire logic [7:0] tx_byte, // Next byte to write
   output logic tx_take, // Pulse: tx_byte consumed
   output logic rx_valid, // Pulse: rx_byte holds a read byte
   output logic [7:0] rx_byte, // Last read byte
   output logic busy, // Transfer in progress
   output logic done, // Pulse: transfer finished
   output logic err // Last transfer saw a missing acknowledge
);
   typedef struct packed {
      scrs_hstate_type st;
      logic [15:0] div;
      logic [1:0] qt;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic scl;
      logic oe;
      logic ackb;
      scrs_op_type op;
      logic [6:0] addr;
      logic [6:0] ofs;
      logic [7:0] len;
      logic [7:0] remain;
      logic cnt_ph;
      logic take;
      logic rxv;
      logic [7:0] rxb;
      logic busy;
      logic done;
      logic err;
   } scrs_host_type;

   scrs_host_type h_q;
   scrs_host_type h_d;
   logic sda_s;
   logic rx_st;
   logic last;

   scrs_sync #(.W(1)) u_sda_sync
   (
      .clk(clk_sys),
      .d(bus.serial_data_line),
      .q(sda_s)
   );

   // Four quarters per bit; clock is divided down from clk_sys
   always_comb
   begin
      h_d = h_q;
      h_d.take = 1'b0;
      h_d.rxv = 1'b0;
      h_d.done = 1'b0;
      rx_st = h_q.st == HS_RDATA;
      last = h_q.cnt_ph ? h_q.remain == 8'h00 : h_q.remain == 8'h01;
      if (h_q.st == HS_IDLE)
      begin
         h_d.div = '0;
         h_d.qt = '0;
         if (go)
         begin
            h_d = '{st: HS_START, op: op, addr: addr, ofs: offset,
                    len: len, busy: 1'b1, scl: 1'b1, default: '0};
         end
      end
      else if (h_q.div != 16'(QTR_CYC - 1))
      begin
         h_d.div = h_q.div + 16'h0001;
      end
      else
      begin
         h_d.div = '0;
         h_d.qt = h_q.qt + 2'h1;
         if (h_q.qt == 2'h1)
         begin
            h_d.scl = 1'b1;
         end
         if (h_q.st == HS_START || h_q.st == HS_RSTART)
         begin
            // Data falls while the clock is high
            h_d.oe = h_q.qt == 2'h2 || (h_q.qt != 2'h0 && h_q.oe);
            if (h_q.qt == 2'h3)
            begin
               h_d.scl = 1'b0;
               h_d.bitn = '0;
               h_d.st = h_q.st == HS_START ? HS_ADDR : HS_RADDR;
               h_d.sh = {h_q.addr, h_q.st == HS_RSTART};
            end
         end
         else if (h_q.st == HS_STOP)
         begin
            // Data rises while the clock is high
            h_d.oe = h_q.qt == 2'h0 || (h_q.qt == 2'h1 && h_q.oe);
            if (h_q.qt == 2'h3)
            begin
               h_d.st = HS_IDLE;
               h_d.busy = 1'b0;
               h_d.done = 1'b1;
            end
         end
         else if (h_q.qt == 2'h0)
         begin
            // Drive data bits, or our acknowledge on reads
            if (h_q.bitn == SCRS_BIT_DONE)
               h_d.oe = rx_st && !last;
            else
               h_d.oe = !rx_st && !h_q.sh[7];
         end
         else if (h_q.qt == 2'h2)
         begin
            if (rx_st && h_q.bitn != SCRS_BIT_DONE)
               h_d.sh = {h_q.sh[6:0], sda_s};
            h_d.ackb = sda_s;
         end
         else if (h_q.qt == 2'h3)
         begin
            h_d.scl = 1'b0;
            if (h_q.bitn != SCRS_BIT_DONE)
            begin
               h_d.bitn = h_q.bitn + 4'h1;
               if (!rx_st)
                  h_d.sh = {h_q.sh[6:0], 1'b0};
            end
            else
            begin
               h_d.bitn = '0;
               // Byte finished: choose what follows
               if (h_q.ackb && !rx_st)
               begin
                  h_d.err = 1'b1;
                  h_d.st = HS_STOP;
               end
               else
               begin
                  case (h_q.st)
                     HS_ADDR:
                     begin
                        h_d.st = HS_CMD;
                        h_d.sh = cmd_code(h_q.op, h_q.ofs);
                     end
                     HS_CMD:
                     begin
                        h_d.remain = op_count(h_q.op, h_q.len);
                        h_d.st = HS_WDATA;
                        h_d.sh = tx_byte;
                        h_d.take = 1'b1;
                        if (op_is_read(h_q.op))
                        begin
                           h_d.st = HS_RSTART;
                           h_d.take = 1'b0;
                        end
                        else if (op_is_block(h_q.op))
                        begin
                           h_d.st = HS_CNT;
                           h_d.sh = h_q.len;
                           h_d.take = 1'b0;
                        end
                     end
                     HS_CNT, HS_WDATA:
                     begin
                        if (h_q.st == HS_WDATA)
                           h_d.remain = h_q.remain - 8'h01;
                        if (h_d.remain == 8'h00)
                           h_d.st = HS_STOP;
                        else
                        begin
                           h_d.st = HS_WDATA;
                           h_d.sh = tx_byte;
                           h_d.take = 1'b1;
                        end
                     end
                     HS_RADDR:
                     begin
                        h_d.st = HS_RDATA;
                        h_d.cnt_ph = op_is_block(h_q.op);
                        h_d.remain = op_count(h_q.op, h_q.len);
                     end
                     default:
                     begin
                        // Read byte: count byte is not passed on
                        h_d.cnt_ph = 1'b0;
                        if (!h_q.cnt_ph)
                        begin
                           h_d.rxv = 1'b1;
                           h_d.rxb = h_q.sh;
                           h_d.remain = h_q.remain - 8'h01;
                        end
                        if (last)
                           h_d.st = HS_STOP;
                     end
                  endcase
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         h_q <= '{st: HS_IDLE, op: OP_BYTE_WR, scl: 1'b1, default: '0};
      end
      else
      begin
         h_q <= h_d;
      end
   end

   assign bus.serial_clock_line = h_q.scl;
   assign bus.sda_host_o = 1'b0;
   assign bus.sda_host_oe = h_q.oe;
   assign tx_take = h_q.take;
   assign rx_valid = h_q.rxv;
   assign rx_byte = h_q.rxb;
   assign busy = h_q.busy;
   assign done = h_q.done;
   assign err = h_q.err;
endmodule // scrs_host

//--- verif/scrs_chk.sv
// Concurrent checks on the two-wire link between host and device
module scrs_chk
(
   input wire logic clk_sys, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic clk_link, // Device link clock
   input wire logic serial_clock_line, // Link clock wire
   input wire logic sda_host_o, // Host data out
   input wire logic sda_host_oe, // Host pulls data low
   input wire logic sda_dev_o, // Device data out
   input wire logic sda_dev_oe, // Device pulls data low
   input wire logic serial_data_line // Resolved data wire
);
   timeunit 1ns;
   timeprecision 1ps;
   logic scl_q; // Link clock seen last link cycle
   logic [7:0] fall_cnt_q; // Link cycles since clock fall, saturating
   logic [3:0] rst_sh_q = 4'hf; // Reset history on the link clock
   logic link_rst; // Device link logic may still be in reset

   // Device link logic leaves reset some link edges after sys_rst does
   assign link_rst = sys_rst || rst_sh_q != 4'h0;

   // Count from each clock fall so the device reaction time is bounded
   always @(posedge clk_link)
   begin
      scl_q <= serial_clock_line;
      rst_sh_q <= {rst_sh_q[2:0], sys_rst};
      if (link_rst || (scl_q && !serial_clock_line))
         fall_cnt_q <= 8'h00;
      else if (fall_cnt_q != 8'hff)
         fall_cnt_q <= fall_cnt_q + 8'h01;
   end

   // Device stays off the line while the host frames a transfer
   a_dev_start_free: assert property (@(posedge clk_sys)
      disable iff (sys_rst) $rose(sda_host_oe) && serial_clock_line |->
      !sda_dev_oe) else $error("device pulled line at start");
   a_dev_stop_free: assert property (@(posedge clk_sys)
      disable iff (sys_rst) $fell(sda_host_oe) && serial_clock_line |->
      !sda_dev_oe) else $error("device pulled line at stop");
   // A pulling end always wins over the pull-up
   a_line_pulled: assert property (@(posedge clk_sys)
      disable iff (sys_rst) ((sda_host_oe && !sda_host_o) ||
      (sda_dev_oe && !sda_dev_o)) |-> !serial_data_line)
      else $error("pulled line not low");
   // Device data may only move while the clock is low
   a_dev_steady_high: assert property (@(posedge clk_link)
      disable iff (link_rst) $changed(sda_dev_oe) |->
      !serial_clock_line && !$past(serial_clock_line))
      else $error("device data moved with clock high");
   a_dev_react_time: assert property (@(posedge clk_link)
      disable iff (link_rst) $changed(sda_dev_oe) |->
      fall_cnt_q inside {[1:10]})
      else $error("device data change not tied to clock fall");
   a_ack_held: assert property (@(posedge clk_sys)
      disable iff (sys_rst) $rose(serial_clock_line) && sda_dev_oe |=>
      sda_dev_oe [*8]) else $error("device released during high clock");
   // Framing made by the host
   a_start_hold: assert property (@(posedge clk_sys)
      disable iff (sys_rst) $rose(sda_host_oe) && serial_clock_line |=>
      serial_clock_line [*4]) else $error("start without clock hold");
   a_stop_idle: assert property (@(posedge clk_sys)
      disable iff (sys_rst) $fell(sda_host_oe) && serial_clock_line |=>
      serial_clock_line [*8]) else $error("clock moved after stop");
   a_clk_high_width: assert property (@(posedge clk_sys)
      disable iff (sys_rst) $rose(serial_clock_line) |=>
      serial_clock_line [*8]) else $error("clock high phase too short");
endmodule // scrs_chk

//--- verif/scrs_tb_top.sv
// Bench joining host and device ends over one two-wire link
module scrs_tb_top import scrs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, clk_link = 0, sys_rst = 1, go = 0;
   scrs_op_type op = OP_BYTE_WR;
   logic [6:0] addr = '0, offset = '0, cfg_wr_idx;
   logic [7:0] len = '0, tx_byte, rx_byte, cfg_wr_data;
   logic tx_take, rx_valid, busy, done, err, cfg_wr_stb;
   logic [7:0] mem [128] = '{default: 8'h00}; // Expected device bytes
   logic [7:0] tx_arr [256] = '{default: 8'h00};
   logic [7:0] wq_d [$], rq [$];
   logic [6:0] wq_i [$];
   int tx_i = 0, n_mismatch = 0, samples_checked = 0, tn = 0;
   logic [31:0] seed = 32'h0000_c224;

   assign tx_byte = tx_arr[tx_i];
   // Clocks; link clock period chosen not to divide the system clock
   always #10 clk_sys = ~clk_sys;
   always #16 clk_link = ~clk_link;

   scrs_if i_scrs_if ();
   scrs_host #(.QTR_CYC(8)) i_scrs_host (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .bus(i_scrs_if), .go(go), .op(op), .addr(addr),
      .offset(offset), .len(len), .tx_byte(tx_byte), .tx_take(tx_take),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .busy(busy), .done(done),
      .err(err));
   scrs_device i_scrs_device (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .clk_link(clk_link), .bus(i_scrs_if), .cfg_wr_stb(cfg_wr_stb),
      .cfg_wr_idx(cfg_wr_idx), .cfg_wr_data(cfg_wr_data));
   scrs_chk i_scrs_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .clk_link(clk_link), .serial_clock_line(i_scrs_if.serial_clock_line),
      .sda_host_o(i_scrs_if.sda_host_o), .sda_host_oe(i_scrs_if.sda_host_oe),
      .sda_dev_o(i_scrs_if.sda_dev_o), .sda_dev_oe(i_scrs_if.sda_dev_oe),
      .serial_data_line(i_scrs_if.serial_data_line));

   // Collect what both ends hand to their user sides
   always @(posedge clk_sys)
   begin
      if (cfg_wr_stb === 1'b1)
      begin
         wq_i.push_back(cfg_wr_idx);
         wq_d.push_back(cfg_wr_data);
      end
      if (rx_valid === 1'b1)
         rq.push_back(rx_byte);
   end
   // Next write byte appears off the edge, like every other input
   always @(posedge clk_sys)
      if (tx_take === 1'b1)
         #2 tx_i++;

   // Data bytes a transfer hands over, from the transfer type and the block length
   function automatic int exp_cnt(input scrs_op_type o, input logic [7:0] n);
      if (o == OP_BLK_WR || o == OP_BLK_RD)
         return n;
      return (o == OP_WORD_WR || o == OP_WORD_RD) ? 2 : 1;
   endfunction

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("Counts: %0d checked, %0d mismatches", samples_checked,
               n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // One transfer: request, bounded wait for done, compare with the model
   task automatic xfer(input scrs_op_type o, input logic [6:0] a,
                       input logic [6:0] ofs, input logic [7:0] n);
      int k, cnt;
      logic blk, rd, own;
      logic [6:0] p, ix;
      blk = o == OP_BLK_WR || o == OP_BLK_RD;
      rd = o == OP_BYTE_RD || o == OP_WORD_RD || o == OP_BLK_RD;
      own = a == SCRS_DEV_ADDR;
      cnt = exp_cnt(o, n);
      p = blk ? 7'h00 : ofs;
      for (k = 0; k < 256; k++)
      begin
         seed = lfsr(seed);
         tx_arr[k] = seed[7:0];
      end
      wq_i.delete();
      wq_d.delete();
      rq.delete();
      tx_i = 0;
      @(posedge clk_sys);
      #2 go = 1;
      op = o;
      addr = a;
      offset = ofs;
      len = n;
      @(posedge clk_sys);
      #2 go = 0;
      chk(busy, 1'b1);
      for (k = 0; k < 20000 && done !== 1'b1; k++)
      begin
         @(posedge clk_sys);
         #2;
      end
      if (k == 20000)
         n_mismatch++;
      chk(busy, 1'b0);
      chk(err, !own);
      if (!own)
         cnt = 0;
      chk(rd ? rq.size() : wq_i.size(), cnt);
      for (k = 0; k < cnt; k++)
      begin
         ix = p + k[6:0];
         if (rd)
            chk(rq[k], mem[ix]);
         else
         begin
            chk(wq_i[k], ix);
            chk(wq_d[k], tx_arr[k]);
            mem[ix] = tx_arr[k];
         end
      end
      tn++;
      $display("Test %0d finished, op %0d", tn, o);
   endtask

   // Corner cases first, then a seeded random mix of all six types
   initial
   begin
      repeat (3) @(posedge clk_sys);
      #2 sys_rst = 0;
      repeat (8) @(posedge clk_sys);
      xfer(OP_BYTE_RD, SCRS_DEV_ADDR, 7'h35, 8'h00); // Reset value
      xfer(OP_WORD_WR, SCRS_DEV_ADDR, 7'h7f, 8'h00); // Wraps past top
      xfer(OP_WORD_RD, SCRS_DEV_ADDR, 7'h7f, 8'h00);
      xfer(OP_BLK_WR, SCRS_DEV_ADDR, 7'h00, 8'h05); // Early block stop
      xfer(OP_BLK_RD, SCRS_DEV_ADDR, 7'h00, 8'h06);
      xfer(OP_BYTE_WR, 7'h12, 7'h03, 8'h00); // Foreign address
      xfer(OP_BLK_WR, SCRS_DEV_ADDR, 7'h00, 8'h00); // Count only
      repeat (14)
      begin
         seed = lfsr(seed);
         xfer(scrs_op_type'(seed[2:0] % 6), seed[8] ? SCRS_DEV_ADDR :
              seed[15:9], seed[22:16], {4'h0, seed[27:24]});
      end
      tally_and_finish();
   end

   // Watchdog: 21 transfers with about 4500 clk_sys cycles allowed for each; a 15-byte block read takes about 5600
   initial
   begin
      #1_900_000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule // scrs_tb_top
